//--- logic/asps_fround.sv
`timescale 1ns/1ns
`default_nettype none
`include "asps_defs.svh"
module asps_fround #(
  parameter int unsigned W = 16
) (
  // Reference in hundredths of a hertz
  input  wire logic [W-1:0] freq_in,
  // High maximum frequency: tenth-hertz steps only
  input  wire logic         coarse,
  output logic [W-1:0]      freq_out
);

  // Sixteen bits are needed for the upper frequency limit
  if (W < 16) begin : g_chk
    $error("asps_fround: W must be at least 16");
  end

  // Drop the hundredths digit when coarse; truncation, never rounds up
  always_comb begin
    if (coarse) begin
      freq_out = freq_in - (freq_in % W'(`ASPS_FSTEP));
    end else begin
      freq_out = freq_in;
    end
  end

endmodule
`default_nettype wire

//--- logic/asps_tick.sv
`timescale 1ns/1ns
`default_nettype none
module asps_tick #(
  parameter int unsigned TICK_CYC = 2
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Restart the tenth-second period
  input  wire logic clr,
  // One-cycle pulse per period
  output logic      tick
);

  // A period below two cycles cannot pulse and restart cleanly
  if (TICK_CYC < 2) begin : g_chk
    $error("asps_tick: TICK_CYC must be at least 2");
  end

  asps_pkg::asps_tick_t st_r;   // Registered state
  asps_pkg::asps_tick_t st_nxt; // Next state

  // Count cycles; a clear aligns the period to a stage start
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (clr) begin
      st_nxt.cnt = 32'h0000_0000;
    end else if (st_r.cnt == 32'(TICK_CYC - 1)) begin
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule
`default_nettype wire

//--- logic/asps_top.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "asps_defs.svh"
// What this block does
// RULE1: Stages 1-15 own frequency, clipped at limit
// RULE2: Stage 0 uses the multi-speed 0 frequency
// RULE3: High maximum frequency forces tenth-hertz steps
// RULE4: Each stage has a duration in tenths
// RULE5: Direction 0 stop, 1 forward, 2 reverse
// RULE6: Wobble or PID enabled keeps program off
// RULE7: All stage times zero keeps program off
// RULE8: Multi-step speed inputs ignored while program on
// RULE9: Program ramps use the general ramp times
// RULE10: Single-cycle mode runs once then stops
// RULE11: Continuous modes restart the cycle forever
// RULE12: Hold mode keeps last stage speed after cycle
// RULE13: Modes 1-3 resume the unfinished stage
// RULE14: Modes 4-6 restart from stage 0
// RULE15: Stages ascend, each lasting its duration
module asps_top #(
  parameter int unsigned TICK_CYC = `ASPS_TICK_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Command pins from the run source
  input  wire logic        run_cmd,
  input  wire logic [3:0]  msp_sel,
  // Towards the ramp generator
  output asps_pkg::asps_drv_t drv,
  output logic [3:0]       msp_sel_eff
);

  asps_pkg::asps_st_t st_r;    // Registered state
  asps_pkg::asps_st_t st_nxt;  // Next state
  logic [15:0]        tnz;     // Stage time non-zero flags
  logic               allzero; // Every stage time is zero
  logic               auto_en; // Program may run
  logic               coarse;  // Tenth-hertz resolution
  logic               tick;    // Tenth-second pulse
  logic               ld;      // Stage load, restarts the tick
  logic               wr;      // Write in access phase
  logic               rd_set;  // Read setup cycle
  logic               hit;     // Address is mapped
  logic [31:0]        rdv;     // Read value of the address
  logic [3:0]         idx;     // Table index from the address
  logic [15:0]        cur_f;   // Raw frequency of this stage
  logic [15:0]        cur_fr;  // Frequency after resolution
  logic [1:0]         cur_d;   // Direction of this stage
  logic               resume;  // Modes that keep the stage
  logic               cont;    // Modes that loop
  logic               holdm;   // Modes that hold last speed
  logic               start;   // Run requested and allowed

  // Clip a written value to a limit; upper word bits count too
  function automatic logic [15:0] clip(input logic [31:0] v,
                                       input logic [15:0] lim);
    clip = (v > {16'h0000, lim}) ? lim : v[15:0];
  endfunction

  // Per-entry zero test of the stage times
  for (genvar g = 0; g < 16; g++) begin : g_tnz
    assign tnz[g] = |st_r.tim[g];
  end

  assign allzero = ~|tnz; // RULE7
  assign coarse  = st_r.maxf > `ASPS_F300; // RULE3
  assign idx     = paddr[5:2];
  assign wr      = psel & penable & pwrite;
  assign rd_set  = psel & ~penable & ~pwrite;
  assign start   = auto_en & st_r.run_s2;

  // Program gate: a valid mode, no wobble, no PID, some stage time
  always_comb begin
    auto_en = (st_r.mode >= `ASPS_M_SINGLE)
            & (st_r.mode <= `ASPS_M_HOLD_N)
            & ~st_r.wob & ~st_r.pid & ~allzero; // RULE6 RULE7
  end

  // Mode classes
  always_comb begin
    resume = (st_r.mode >= `ASPS_M_SINGLE)
           & (st_r.mode <= `ASPS_M_HOLD); // RULE13
    cont   = (st_r.mode == `ASPS_M_CONT)
           | (st_r.mode == `ASPS_M_CONT_N); // RULE11
    holdm  = (st_r.mode == `ASPS_M_HOLD)
           | (st_r.mode == `ASPS_M_HOLD_N); // RULE12
  end

  // Stage zero borrows the multi-speed 0 frequency
  always_comb begin
    if (st_r.stage == 4'h0) begin
      cur_f = st_r.f0; // RULE2
    end else begin
      cur_f = st_r.freq[st_r.stage]; // RULE1
    end
    cur_d = st_r.dir[st_r.stage];
  end

  // Resolution reduction for high maximum frequencies
  asps_fround #(
    .W        (16)
  ) u_fround (
    .freq_in  (cur_f),
    .coarse   (coarse),
    .freq_out (cur_fr)
  );

  // Tenth-second time base, realigned at every stage load
  asps_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .mclk     (mclk),
    .reset    (reset),
    .clr      (ld),
    .tick     (tick)
  );

  // Register access, sequencing and output drive
  always_comb begin
    st_nxt = st_r;
    ld = 1'b0;
    hit = 1'b1;
    rdv = 32'h0000_0000;
    // Pins come from another domain: two flops before use
    st_nxt.run_s1 = run_cmd;
    st_nxt.run_s2 = st_r.run_s1;
    st_nxt.msp_s1 = msp_sel;
    st_nxt.msp_s2 = st_r.msp_s1;

    // Address decode
    if (paddr == `ASPS_CTRL_OFS) begin
      rdv = {26'h0, st_r.pid, st_r.wob, 1'b0, st_r.mode};
      if (wr) begin
        st_nxt.mode = pwdata[`ASPS_MODE_MSB:0];
        st_nxt.wob  = pwdata[`ASPS_WOB_BIT];
        st_nxt.pid  = pwdata[`ASPS_PID_BIT];
      end
    end else if (paddr == `ASPS_STAT_OFS) begin
      // Read-only view of the sequencer
      rdv = {st_r.rem, 5'h00, st_r.fresh, allzero, auto_en,
             st_r.state, st_r.stage};
    end else if (paddr == `ASPS_F0_OFS) begin
      rdv = {16'h0000, st_r.f0};
      if (wr) begin
        st_nxt.f0 = clip(pwdata, `ASPS_FMAX); // RULE2
      end
    end else if (paddr == `ASPS_MAXF_OFS) begin
      rdv = {16'h0000, st_r.maxf};
      if (wr) begin
        st_nxt.maxf = pwdata[15:0];
      end
    end else if (((paddr & `ASPS_TBL_MASK) == `ASPS_FREQ_BASE)
                 && (idx != 4'h0)) begin
      // Stage 0 slot is absent: its frequency lives above
      rdv = {16'h0000, st_r.freq[idx]};
      if (wr) begin
        st_nxt.freq[idx] = clip(pwdata, `ASPS_FMAX); // RULE1
      end
    end else if ((paddr & `ASPS_TBL_MASK) == `ASPS_TIME_BASE) begin
      rdv = {16'h0000, st_r.tim[idx]};
      if (wr) begin
        st_nxt.tim[idx] = clip(pwdata, `ASPS_TMAX); // RULE4
      end
    end else if ((paddr & `ASPS_TBL_MASK) == `ASPS_DIR_BASE) begin
      rdv = {30'h0, st_r.dir[idx]};
      if (wr) begin
        st_nxt.dir[idx] = pwdata[1:0];
      end
    end else begin
      // Unmapped: no store, reads zero, error flagged
      hit = 1'b0;
    end

    // Read data is captured in setup so it is stable in access
    if (rd_set) begin
      st_nxt.prdata = rdv;
    end

    // Sequencer
    case (st_r.state)
      asps_pkg::ASPS_IDLE: begin
        if (start) begin
          st_nxt.state = asps_pkg::ASPS_RUN;
          ld = 1'b1;
          if (!resume || st_r.fresh) begin
            // New cycle from the first stage
            st_nxt.stage = 4'h0; // RULE14
            st_nxt.rem = st_r.tim[0];
            st_nxt.fresh = 1'b0;
          end
          // Otherwise stage and time left are kept // RULE13
        end
      end
      asps_pkg::ASPS_RUN: begin
        if (!start) begin
          // Stop: leave the stage and remaining time intact
          st_nxt.state = asps_pkg::ASPS_IDLE;
        end else if (st_r.rem == 16'h0000) begin
          ld = 1'b1;
          if (st_r.stage != 4'hf) begin
            st_nxt.stage = st_r.stage + 4'h1; // RULE15
            st_nxt.rem = st_r.tim[st_r.stage + 4'h1];
          end else if (cont) begin
            st_nxt.stage = 4'h0; // RULE11
            st_nxt.rem = st_r.tim[0];
          end else if (holdm) begin
            st_nxt.state = asps_pkg::ASPS_HOLD; // RULE12
          end else begin
            st_nxt.state = asps_pkg::ASPS_DONE; // RULE10
            st_nxt.fresh = 1'b1;
          end
        end else if (tick) begin
          st_nxt.rem = st_r.rem - 16'h0001; // RULE4 RULE15
        end
      end
      asps_pkg::ASPS_HOLD: begin
        // Cycle is complete, so the next run starts afresh
        if (!start) begin
          st_nxt.state = asps_pkg::ASPS_IDLE;
          st_nxt.fresh = 1'b1;
        end
      end
      asps_pkg::ASPS_DONE: begin
        // Output stopped until the run command is removed
        if (!st_r.run_s2) begin
          st_nxt.state = asps_pkg::ASPS_IDLE;
        end
      end
      default: begin
        st_nxt.state = asps_pkg::ASPS_IDLE;
      end
    endcase

    // Drive towards the ramp generator, one cycle behind state
    st_nxt.drv.active = auto_en;
    st_nxt.drv.gen_ramp = auto_en; // RULE9
    st_nxt.drv.fwd = 1'b0;
    st_nxt.drv.rev = 1'b0;
    st_nxt.drv.freq = 16'h0000;
    if ((st_r.state == asps_pkg::ASPS_RUN)
        || (st_r.state == asps_pkg::ASPS_HOLD)) begin
      // Code 3 is undefined and treated as stop
      if (cur_d == `ASPS_D_FWD) begin
        st_nxt.drv.fwd = 1'b1; // RULE5
        st_nxt.drv.freq = cur_fr;
      end else if (cur_d == `ASPS_D_REV) begin
        st_nxt.drv.rev = 1'b1; // RULE5
        st_nxt.drv.freq = cur_fr;
      end
    end

    // Multi-step speed selections are masked while the program owns
    if (auto_en) begin
      st_nxt.msp_eff = 4'h0; // RULE8
    end else begin
      st_nxt.msp_eff = st_r.msp_s2;
    end
  end

  // State register; reset leaves the program disabled
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.state <= asps_pkg::ASPS_IDLE;
      st_r.mode <= `ASPS_MODE_RST;
      st_r.fresh <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs; zero-wait slave
  assign prdata      = st_r.prdata;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~hit;
  assign drv         = st_r.drv;
  assign msp_sel_eff = st_r.msp_eff;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Last stage expiring while allowed to run
  sequence end15_s;
    (st_r.state == asps_pkg::ASPS_RUN) && (st_r.stage == 4'hf)
      && (st_r.rem == 16'h0000) && start;
  endsequence

  // Start from idle
  sequence go_s;
    (st_r.state == asps_pkg::ASPS_IDLE) && start;
  endsequence

  freq_clip_a: assert property ( // RULE1
    (wr && ((paddr & `ASPS_TBL_MASK) == `ASPS_FREQ_BASE) && idx != 4'h0
      && pwdata > {16'h0000, `ASPS_FMAX})
    |=> st_r.freq[$past(idx)] == `ASPS_FMAX)
    else $error("stage frequency not clipped");

  stage0_freq_a: assert property ( // RULE2
    (st_r.state == asps_pkg::ASPS_RUN) && st_r.stage == 4'h0
      && cur_d == `ASPS_D_FWD && !coarse
    |=> drv.freq == $past(st_r.f0))
    else $error("stage 0 frequency wrong");

  coarse_res_a: assert property ( // RULE3
    coarse |=> (drv.freq % `ASPS_FSTEP) == 16'h0000)
    else $error("resolution not reduced");

  time_clip_a: assert property ( // RULE4
    (wr && ((paddr & `ASPS_TBL_MASK) == `ASPS_TIME_BASE)
      && pwdata > {16'h0000, `ASPS_TMAX})
    |=> st_r.tim[$past(idx)] == `ASPS_TMAX)
    else $error("stage time not clipped");

  dir_rev_a: assert property ( // RULE5
    (st_r.state == asps_pkg::ASPS_RUN) && cur_d == `ASPS_D_REV
    |=> drv.rev && !drv.fwd)
    else $error("reverse direction not driven");

  lock_out_a: assert property ( // RULE6 RULE7
    (st_r.wob || st_r.pid || allzero)
    |=> !drv.active && st_r.state != asps_pkg::ASPS_RUN)
    else $error("program active while locked out");

  msp_mask_a: assert property ( // RULE8
    auto_en |=> msp_sel_eff == 4'h0)
    else $error("multi-step inputs leak through");

  single_stop_a: assert property ( // RULE10
    end15_s ##0 (st_r.mode == `ASPS_M_SINGLE
      || st_r.mode == `ASPS_M_SINGLE_N)
    |=> st_r.state == asps_pkg::ASPS_DONE
        ##1 (drv.freq == 16'h0000 && !drv.fwd && !drv.rev))
    else $error("single cycle did not stop");

  cont_loop_a: assert property ( // RULE11
    end15_s ##0 cont
    |=> st_r.state == asps_pkg::ASPS_RUN && st_r.stage == 4'h0)
    else $error("continuous cycle did not restart");

  hold_last_a: assert property ( // RULE12
    end15_s ##0 holdm
    |=> st_r.state == asps_pkg::ASPS_HOLD && st_r.stage == 4'hf)
    else $error("last speed not held");

  resume_stage_a: assert property ( // RULE13
    go_s ##0 (resume && !st_r.fresh)
    |=> st_r.stage == $past(st_r.stage) && st_r.rem == $past(st_r.rem))
    else $error("unfinished stage not resumed");

  restart_new_a: assert property ( // RULE14
    go_s ##0 !resume |=> st_r.stage == 4'h0)
    else $error("cycle not restarted at stage 0");

  stage_step_a: assert property ( // RULE15
    (st_r.state == asps_pkg::ASPS_RUN) && st_r.rem == 16'h0000
      && st_r.stage != 4'hf && start
    |=> st_r.stage == $past(st_r.stage) + 4'h1)
    else $error("stage did not advance by one");

endmodule
`default_nettype wire

//--- shared/asps_defs.svh
`ifndef ASPS_DEFS_SVH
`define ASPS_DEFS_SVH

// Clock period and stage time base
`define ASPS_CLK_NS     50
`define ASPS_TICK_MS    100
`define ASPS_TICK_CYC   ((`ASPS_TICK_MS * 1000000) / `ASPS_CLK_NS)

// Register byte offsets
`define ASPS_CTRL_OFS   8'h00
`define ASPS_STAT_OFS   8'h04
`define ASPS_F0_OFS     8'h08
`define ASPS_MAXF_OFS   8'h0c
`define ASPS_FREQ_BASE  8'h40
`define ASPS_TIME_BASE  8'h80
`define ASPS_DIR_BASE   8'hc0
`define ASPS_TBL_MASK   8'hc3

// Control field positions
`define ASPS_MODE_MSB   2
`define ASPS_WOB_BIT    4
`define ASPS_PID_BIT    5

// Reset values
`define ASPS_MODE_RST   3'h0

// Limits: hundredths of a hertz, tenths of a second
`define ASPS_FMAX       16'he9fc
`define ASPS_TMAX       16'hea60
`define ASPS_F300       16'h7530
`define ASPS_FSTEP      16'h000a

// Program mode values
`define ASPS_M_SINGLE   3'h1
`define ASPS_M_CONT     3'h2
`define ASPS_M_HOLD     3'h3
`define ASPS_M_SINGLE_N 3'h4
`define ASPS_M_CONT_N   3'h5
`define ASPS_M_HOLD_N   3'h6

// Stage direction codes
`define ASPS_D_STOP     2'h0
`define ASPS_D_FWD      2'h1
`define ASPS_D_REV      2'h2

`endif

//--- shared/asps_pkg.sv
package asps_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ASPS_IDLE = 4'h1,
    ASPS_RUN  = 4'h2,
    ASPS_HOLD = 4'h4,
    ASPS_DONE = 4'h8
  } asps_state_t;

  // Bundle handed to the ramp generator
  typedef struct packed {
    logic [15:0] freq;
    logic        fwd;
    logic        rev;
    logic        active;
    logic        gen_ramp;
  } asps_drv_t;

  // Time base state
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } asps_tick_t;

  // Whole sequencer state
  typedef struct packed {
    asps_state_t       state;
    logic [3:0]        stage;
    logic [15:0]       rem;
    logic              fresh;
    logic              run_s1;
    logic              run_s2;
    logic [3:0]        msp_s1;
    logic [3:0]        msp_s2;
    logic [2:0]        mode;
    logic              wob;
    logic              pid;
    logic [15:0]       f0;
    logic [15:0]       maxf;
    logic [15:0][15:0] freq;
    logic [15:0][15:0] tim;
    logic [15:0][1:0]  dir;
    logic [31:0]       prdata;
    asps_drv_t         drv;
    logic [3:0]        msp_eff;
  } asps_st_t;

endpackage

//--- tb/asps_drive_side.sv
`timescale 1ns/1ns
`default_nettype none
// Run switch and output ramp generator facing the sequencer
module asps_drive_side #(
  parameter int LAG = 1  // Delay tap; a run request takes LAG+1 cycles to reach the pin
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                reset,
  // Requests from the bench
  input  wire logic                run_req,
  input  wire logic [3:0]          msp_req,
  // Sequencer output
  input  wire asps_pkg::asps_drv_t drv,
  // Pins into the sequencer
  output logic                     run_cmd,
  output logic [3:0]               msp_sel,
  // Ramped output frequency
  output logic [15:0]              ramp_r
);
  logic [3:0] lag_r;  // Delay line, lets a slow switch be modelled

  // Delay the run switch and slew towards the reference
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lag_r  <= 4'h0;
      ramp_r <= 16'h0000;
    end else begin
      lag_r <= {lag_r[2:0], run_req};
      // Ramp only under the general ramp times, else drop to zero at once
      if (!drv.gen_ramp) begin
        ramp_r <= 16'h0000;
      end else if (ramp_r < drv.freq) begin
        ramp_r <= ramp_r + 16'h0001;
      end else if (ramp_r > drv.freq) begin
        ramp_r <= ramp_r - 16'h0001;
      end
    end
  end
  assign run_cmd = lag_r[LAG];
  assign msp_sel = msp_req;
endmodule
`default_nettype wire

//--- tb/asps_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "asps_defs.svh"
module asps_top_tb;
  localparam int TC = 4;  // Short tenth period keeps the run brief
  localparam logic [2:0] MT [6] = '{`ASPS_M_SINGLE, `ASPS_M_CONT,
    `ASPS_M_SINGLE_N, `ASPS_M_HOLD, `ASPS_M_CONT_N, `ASPS_M_HOLD_N};
  logic                mclk, reset, psel, penable, pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, seed;
  logic                pready, pslverr, run_req, run_cmd;
  logic [3:0]          msp_req, msp_sel, msp_sel_eff;
  asps_pkg::asps_drv_t drv;
  int                  failures, num_checks;
  logic [15:0]         fv [16];  // Stage frequencies written
  logic [1:0]          dv [16];  // Stage directions written
  logic [17:0]         prev;     // Last drive seen, {freq, fwd, rev}
  logic [17:0]         seen [$]; // Turning stages in order of arrival
  logic [17:0]         want [$]; // Expected turning stages

  // Free-running clock
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  asps_top #(.TICK_CYC(TC)) dut (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
    .msp_sel(msp_sel), .drv(drv), .msp_sel_eff(msp_sel_eff));
  asps_drive_side #(.LAG(2)) far (
    .mclk(mclk), .reset(reset), .run_req(run_req), .msp_req(msp_req),
    .drv(drv), .run_cmd(run_cmd), .msp_sel(msp_sel), .ramp_r());

  // Log each new drive; stopped outputs clear the memory so a resume shows
  always @(posedge mclk) begin
    if ({drv.freq, drv.fwd, drv.rev} !== prev) begin
      prev = {drv.freq, drv.fwd, drv.rev};
      if (drv.fwd | drv.rev) seen.push_back(prev);
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] clip(logic [31:0] v, logic [31:0] m);
    return (v > m) ? m : v;
  endfunction
  // Expected drive of a stage
  function automatic logic [17:0] ent(int s);
    return {fv[s], dv[s] == `ASPS_D_FWD, dv[s] == `ASPS_D_REV};
  endfunction

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tdone(string n);
    $display("Test %s finished", n);
  endtask
  // One APB transfer; the bounded wait guards against a stuck slave
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] x, logic ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(32'(e), 32'(ex));
  endtask
  task automatic waitq(int n);
    for (int k = 0; k < 3000 && seen.size() < n; k++) @(posedge mclk);
    if (seen.size() < n) begin
      failures++;
      test_done();
    end
  endtask
  // Speed pins pass only while the program is off
  task automatic mspc(logic act);
    logic [3:0] v;
    v = 4'(rnd());
    msp_req <= v;
    repeat (6) @(posedge mclk);
    chk(32'(msp_sel_eff), act ? 32'h0 : 32'(v));
    chk(32'(drv.active), 32'(act));
    chk(32'(drv.gen_ramp), 32'(act));
  endtask
  task automatic addw(int s);
    if (dv[s] == `ASPS_D_FWD || dv[s] == `ASPS_D_REV) want.push_back(ent(s));
  endtask

  initial begin
    seed = 32'hb2de7fd0;
    prev = 18'h0;
    failures = 0;
    num_checks = 0;
    {reset, psel, penable, pwrite, run_req} = 5'h10;
    {paddr, pwdata, msp_req} = 44'h0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rdc(`ASPS_CTRL_OFS, 32'h0, 1'b0);
    rdc(`ASPS_FREQ_BASE, 32'h0, 1'b1);
    rdc(8'h10, 32'h0, 1'b1);
    // Gate stays shut while every stage time is zero
    wr(`ASPS_CTRL_OFS, {29'h0, `ASPS_M_CONT});
    run_req <= 1'b1;
    mspc(1'b0);
    run_req <= 1'b0;
    tdone("reset");
    // Table limits, boundary values on entries 1 to 3, random words elsewhere
    for (int i = 0; i < 16; i++) begin
      logic [31:0] v, t;
      logic [7:0]  fa, ta, da;
      v = (i == 1) ? 32'd59900 : (i == 2) ? 32'd59901 : rnd() & 32'h1ffff;
      t = (i == 3) ? 32'd60001 : rnd() & 32'h1ffff;
      fa = (i == 0) ? `ASPS_F0_OFS : `ASPS_FREQ_BASE + 8'(4 * i);
      ta = `ASPS_TIME_BASE + 8'(4 * i);
      da = `ASPS_DIR_BASE + 8'(4 * i);
      wr(fa, v);
      rdc(fa, clip(v, 32'd59900), 1'b0);
      wr(ta, t);
      rdc(ta, clip(t, 32'd60000), 1'b0);
      wr(da, t);
      rdc(da, t & 32'h3, 1'b0);
    end
    tdone("tables");
    // Program: distinct speeds, stop codes on stages 4 and 9
    wr(`ASPS_MAXF_OFS, 32'd30000);
    for (int s = 0; s < 16; s++) begin
      fv[s] = (s == 15) ? 16'd28003 : 16'(s * 1800 + 100 + rnd() % 900);
      dv[s] = (s == 4) ? 2'h0 : (s == 9) ? 2'h3 : 2'(1 + rnd() % 2);
      wr(s == 0 ? `ASPS_F0_OFS : `ASPS_FREQ_BASE + 8'(4 * s), 32'(fv[s]));
      wr(`ASPS_TIME_BASE + 8'(4 * s), 32'h2);
      wr(`ASPS_DIR_BASE + 8'(4 * s), 32'(dv[s]));
    end
    // Every mode, with a stop inside stage 2; order avoids stale resumes
    foreach (MT[m]) begin
      logic [2:0] md;
      logic       lp;
      md = MT[m];
      lp = (md == `ASPS_M_CONT || md == `ASPS_M_CONT_N);
      wr(`ASPS_CTRL_OFS, {29'h0, md});
      seen.delete();
      want.delete();
      for (int s = 0; s < 3; s++) addw(s);
      for (int s = (md <= `ASPS_M_HOLD) ? 2 : 0; s < 16; s++) addw(s);
      if (lp) addw(0);
      if (lp) addw(1);
      run_req <= 1'b1;
      waitq(3);
      run_req <= 1'b0;
      repeat (10) @(posedge mclk);
      run_req <= 1'b1;
      waitq(want.size());
      if (!lp) repeat (60) @(posedge mclk);
      chk(32'(seen.size()), 32'(want.size()));
      foreach (want[k]) chk(32'(seen[k]), 32'(want[k]));
      if (md == `ASPS_M_SINGLE || md == `ASPS_M_SINGLE_N) begin
        chk(32'({drv.fwd, drv.rev}), 32'h0);
      end else if (!lp) begin
        chk(32'({drv.freq, drv.fwd, drv.rev}), 32'(ent(15)));
      end
      if (md != `ASPS_M_HOLD_N) begin
        run_req <= 1'b0;
        repeat (10) @(posedge mclk);
      end
      tdone("mode");
    end
    // Still holding stage 15: coarse steps above the threshold
    wr(`ASPS_MAXF_OFS, 32'd30001);
    repeat (3) @(posedge mclk);
    chk(32'(drv.freq), 32'd28000);
    wr(`ASPS_MAXF_OFS, 32'd30000);
    repeat (3) @(posedge mclk);
    chk(32'(drv.freq), 32'd28003);
    mspc(1'b1);
    // Wobble, then PID, each shuts the program off
    for (int b = 4; b < 6; b++) begin
      wr(`ASPS_CTRL_OFS, (32'h1 << b) | 32'(`ASPS_M_HOLD_N));
      mspc(1'b0);
      chk(32'({drv.fwd, drv.rev}), 32'h0);
    end
    tdone("lockout");
    test_done();
  end
endmodule
`default_nettype wire
